/* core/ppfm_consts.vh */
// constants for the port pin function multiplexer
`ifndef PPFM_CONSTS_VH
`define PPFM_CONSTS_VH

// function selector width and codes
`define PPFM_SEL_W        3
`define PPFM_SEL_GPIO     3'h0
`define PPFM_SEL_ANALOG   3'h1
`define PPFM_SEL_TIMER    3'h2
`define PPFM_SEL_XBAR     3'h3
`define PPFM_SEL_SERIAL   3'h4
`define PPFM_SEL_ASYNC    3'h5
`define PPFM_SEL_XBAR_OUT 3'h6

// number of pins in the group
`define PPFM_NPINS        9

// pin index positions
`define PPFM_PIN_B0       0
`define PPFM_PIN_B1       1
`define PPFM_PIN_B2       2
`define PPFM_PIN_B3       3
`define PPFM_PIN_B4       4
`define PPFM_PIN_C6       5
`define PPFM_PIN_C7       6
`define PPFM_PIN_C8       7
`define PPFM_PIN_C9       8

// reset values
`define PPFM_RST_SEL      27'h0000000
`define PPFM_RST_DIR      9'h000
`define PPFM_RST_OUT      9'h000

`endif

/* core/ppfm_sync2.v */
// two flip-flop synchroniser for a vector of pin inputs
`timescale 1ns/10ps
`default_nettype none

module ppfm_sync2 #(
  parameter W = 9
) (
  // clock and reset
  input  wire         i_clk_sys,
  input  wire         i_arst_n,
  // data
  input  wire [W-1:0] i_async,
  output wire [W-1:0] o_sync
);

  reg [W-1:0] meta_q;
  reg [W-1:0] sync_q;

  // first stage feeds only the second stage
  always @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      meta_q <= {W{1'b0}};
      sync_q <= {W{1'b0}};
    end else begin
      meta_q <= i_async;
      sync_q <= meta_q;
    end
  end

  assign o_sync = sync_q;

endmodule

`default_nettype wire

/* core/ppfm_mux.v */
// function multiplexer for a group of general-purpose port pins
//
// Summary of operation
// - Each pin has its own software direction bit choosing input or output.
// - After any reset every pin is a general-purpose I/O with output off.
// - A converter control bit picks channel 2 or the high reference on b2.
// - An analog pin feeds its converter channel and comparator input at once.
// - The shared reference pin feeds input 5 of all four comparators.
// - Serial clock pin drives out as master and is the clock input as slave.
// - Master-in/slave-out is an input as master and an output as slave.
// - As slave the master-in/slave-out line floats while not selected.
// - The outside master selects the slave; the port drives data only then, but the clock input passes whether or not selected.
// - Async transmit pin sends data, and carries both ways in single wire.
`timescale 1ns/10ps
`default_nettype none
`include "ppfm_consts.vh"

module ppfm_mux #(
  parameter NPINS = `PPFM_NPINS,
  parameter SELW  = `PPFM_SEL_W
) (
  // clock and reset
  input  wire                  i_clk_sys,
  input  wire                  i_arst_n,
  // software configuration, loaded on write strobe
  input  wire                  i_cfg_we,
  input  wire [NPINS*SELW-1:0] i_cfg_sel,
  input  wire [NPINS-1:0]      i_cfg_dir,
  input  wire [NPINS-1:0]      i_cfg_out,
  input  wire                  i_conv_b_ref_sel,
  input  wire                  i_serial0_master,
  input  wire                  i_async0_single_wire,
  // pins, three signals each
  input  wire [NPINS-1:0]      i_pin,
  output wire [NPINS-1:0]      o_pin,
  output wire [NPINS-1:0]      o_pin_oe,
  // general purpose input readback
  output reg  [NPINS-1:0]      o_gpio_in,
  // analog routing enables (analog path is a switched connection)
  output wire [7:0]            o_conv_b_channel_en,
  output wire                  o_conv_b_ref_high_en,
  output wire [3:0]            o_comparator_b_input_en,
  output wire [3:0]            o_comparator_c_input_en,
  output wire [3:0]            o_comparator_ref5_en,
  // quad timer a channel 2
  input  wire                  i_quad_timer_a_channel2_out,
  input  wire                  i_quad_timer_a_channel2_oe,
  output wire                  o_quad_timer_a_channel2_in,
  // crossbar
  output wire                  o_crossbar_input3,
  output wire                  o_crossbar_input4,
  output wire                  o_crossbar_input8,
  output wire                  o_crossbar_input9,
  input  wire                  i_crossbar_output6,
  input  wire                  i_crossbar_output8,
  // synchronous serial port 0
  input  wire                  i_serial0_clock_out,
  output wire                  o_serial0_clock_in,
  input  wire                  i_serial0_miso_out,
  output wire                  o_serial0_miso_in,
  output wire                  o_serial0_slave_select_n,
  output wire                  o_serial0_selected,
  // asynchronous serial port 0
  input  wire                  i_async0_transmit_data,
  input  wire                  i_async0_transmit_en,
  output wire                  o_async0_receive_data
);

  // ---------------------------------------------------------------
  // configuration registers
  // ---------------------------------------------------------------
  reg [NPINS*SELW-1:0] sel_q;
  reg [NPINS-1:0]      dir_q;
  reg [NPINS-1:0]      out_q;
  reg                  ref_sel_q;
  reg                  master_q;
  reg                  single_q;

  // all pins fall back to gpio input on reset
  // the whole word loads at once so a pin never sees a half-written code
  always @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      sel_q     <= `PPFM_RST_SEL;
      dir_q     <= `PPFM_RST_DIR;
      out_q     <= `PPFM_RST_OUT;
      ref_sel_q <= 1'b0;
      master_q  <= 1'b0;
      single_q  <= 1'b0;
    end else if (i_cfg_we) begin
      sel_q     <= i_cfg_sel;
      dir_q     <= i_cfg_dir;
      out_q     <= i_cfg_out;
      ref_sel_q <= i_conv_b_ref_sel;
      master_q  <= i_serial0_master;
      single_q  <= i_async0_single_wire;
    end
  end

  // ---------------------------------------------------------------
  // pin input synchroniser
  // ---------------------------------------------------------------
  // every pin input path reads the synced copy, never the raw pin
  wire [NPINS-1:0] pin_s;

  ppfm_sync2 #(
    .W(NPINS)
  ) u_sync (
    .i_clk_sys (i_clk_sys),
    .i_arst_n  (i_arst_n),
    .i_async   (i_pin),
    .o_sync    (pin_s)
  );

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // function code of one pin
  function [SELW-1:0] fsel;
    input [NPINS*SELW-1:0] v;
    input integer          idx;
    begin
      fsel = v[idx*SELW +: SELW];
    end
  endfunction

  // true when pin idx has function code f
  function is_fn;
    input [NPINS*SELW-1:0] v;
    input integer          idx;
    input [SELW-1:0]       f;
    begin
      is_fn = (fsel(v, idx) == f);
    end
  endfunction

  // ---------------------------------------------------------------
  // function decode
  // ---------------------------------------------------------------
  // codes 7 and above select nothing and leave the pin undriven
  wire an_b0  = is_fn(sel_q, `PPFM_PIN_B0, `PPFM_SEL_ANALOG);
  wire an_b1  = is_fn(sel_q, `PPFM_PIN_B1, `PPFM_SEL_ANALOG);
  wire an_b2  = is_fn(sel_q, `PPFM_PIN_B2, `PPFM_SEL_ANALOG);
  wire an_b3  = is_fn(sel_q, `PPFM_PIN_B3, `PPFM_SEL_ANALOG);
  wire an_b4  = is_fn(sel_q, `PPFM_PIN_B4, `PPFM_SEL_ANALOG);
  wire an_c6  = is_fn(sel_q, `PPFM_PIN_C6, `PPFM_SEL_ANALOG);
  wire tmr_c6 = is_fn(sel_q, `PPFM_PIN_C6, `PPFM_SEL_TIMER);
  wire xb_c6  = is_fn(sel_q, `PPFM_PIN_C6, `PPFM_SEL_XBAR);
  wire ss_c6  = is_fn(sel_q, `PPFM_PIN_C6, `PPFM_SEL_SERIAL);
  wire ss_c7  = is_fn(sel_q, `PPFM_PIN_C7, `PPFM_SEL_SERIAL);
  wire tx_c7  = is_fn(sel_q, `PPFM_PIN_C7, `PPFM_SEL_ASYNC);
  wire xb_c7  = is_fn(sel_q, `PPFM_PIN_C7, `PPFM_SEL_XBAR);
  wire mi_c8  = is_fn(sel_q, `PPFM_PIN_C8, `PPFM_SEL_SERIAL);
  wire rx_c8  = is_fn(sel_q, `PPFM_PIN_C8, `PPFM_SEL_ASYNC);
  wire xb_c8  = is_fn(sel_q, `PPFM_PIN_C8, `PPFM_SEL_XBAR);
  wire xo_c8  = is_fn(sel_q, `PPFM_PIN_C8, `PPFM_SEL_XBAR_OUT);
  wire ck_c9  = is_fn(sel_q, `PPFM_PIN_C9, `PPFM_SEL_SERIAL);
  wire xb_c9  = is_fn(sel_q, `PPFM_PIN_C9, `PPFM_SEL_XBAR);
  wire tx_c9  = is_fn(sel_q, `PPFM_PIN_C9, `PPFM_SEL_ASYNC);
  wire xo_c9  = is_fn(sel_q, `PPFM_PIN_C9, `PPFM_SEL_XBAR_OUT);

  // ---------------------------------------------------------------
  // analog routing
  // ---------------------------------------------------------------
  // one pin feeds channel and comparator together
  assign o_conv_b_channel_en = {3'h0, an_b4, an_b3,
                                an_b2 & ~ref_sel_q, an_b1, an_b0};
  // b3 also carries the low reference, which this block does not route
  assign o_conv_b_ref_high_en    = an_b2 & ref_sel_q;
  assign o_comparator_b_input_en = {an_b0, 2'h0, an_b1};
  assign o_comparator_c_input_en = {an_b2, 1'b0, an_b4, an_b3};
  // shared reference fans to input 5 of all comparators
  assign o_comparator_ref5_en    = {4{an_c6}};

  // ---------------------------------------------------------------
  // slave select and serial roles
  // ---------------------------------------------------------------
  // select taken from whichever pin is configured for it, active low
  wire ss_n = ss_c6 ? pin_s[`PPFM_PIN_C6] :
              ss_c7 ? pin_s[`PPFM_PIN_C7] : 1'b1;
  wire slave    = ~master_q;
  wire selected = slave & ~ss_n;

  assign o_serial0_slave_select_n = ss_n;
  assign o_serial0_selected       = selected;
  // clock input only meaningful as slave
  assign o_serial0_clock_in = ck_c9 & slave & pin_s[`PPFM_PIN_C9];
  // data input only as master
  assign o_serial0_miso_in  = mi_c8 & master_q &
                              pin_s[`PPFM_PIN_C8];

  // ---------------------------------------------------------------
  // async serial and other inputs
  // ---------------------------------------------------------------
  // single wire: receive is taken back from the transmit pin, so the
  // peripheral hears its own frames; line idles high when unrouted
  reg rx_d;

  always @* begin
    rx_d = 1'h1;
    if (single_q) begin
      if (tx_c7) begin
        rx_d = pin_s[`PPFM_PIN_C7];
      end else if (tx_c9) begin
        rx_d = pin_s[`PPFM_PIN_C9];
      end
    end else if (rx_c8) begin
      rx_d = pin_s[`PPFM_PIN_C8];
    end
  end

  assign o_async0_receive_data = rx_d;
  // peripheral inputs read low while their pin serves another function
  assign o_quad_timer_a_channel2_in = tmr_c6 & pin_s[`PPFM_PIN_C6];
  assign o_crossbar_input3 = xb_c6 & pin_s[`PPFM_PIN_C6];
  assign o_crossbar_input4 = xb_c9 & pin_s[`PPFM_PIN_C9];
  assign o_crossbar_input8 = xb_c7 & pin_s[`PPFM_PIN_C7];
  assign o_crossbar_input9 = xb_c8 & pin_s[`PPFM_PIN_C8];

  // readback of every synced pin level, whatever its function
  always @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_gpio_in <= {NPINS{1'b0}};
    end else begin
      o_gpio_in <= pin_s;
    end
  end

  // ---------------------------------------------------------------
  // pin drivers
  // ---------------------------------------------------------------
  // only the selected function drives each pin
  // a pin whose code matches no function stays an undriven input
  reg [NPINS-1:0] drv_d;
  reg [NPINS-1:0] oe_d;
  integer         k;

  always @* begin
    drv_d = {NPINS{1'b0}};
    oe_d  = {NPINS{1'b0}};
    for (k = 0; k < NPINS; k = k + 1) begin
      if (fsel(sel_q, k) == `PPFM_SEL_GPIO) begin
        drv_d[k] = out_q[k];
        oe_d[k]  = dir_q[k];
      end
    end
    // analog pins are never driven digitally
    // each branch below overrides the gpio default of one pin
    // timer channel on c6
    if (tmr_c6) begin
      drv_d[`PPFM_PIN_C6] = i_quad_timer_a_channel2_out;
      oe_d[`PPFM_PIN_C6]  = i_quad_timer_a_channel2_oe;
    end
    // transmit on c7; single wire drives only while sending
    if (tx_c7) begin
      drv_d[`PPFM_PIN_C7] = i_async0_transmit_data;
      oe_d[`PPFM_PIN_C7]  = ~single_q | i_async0_transmit_en;
    end
    // miso: output as slave, floating unless selected
    if (mi_c8) begin
      drv_d[`PPFM_PIN_C8] = i_serial0_miso_out;
      oe_d[`PPFM_PIN_C8]  = selected;
    end
    if (xo_c8) begin
      drv_d[`PPFM_PIN_C8] = i_crossbar_output6;
      oe_d[`PPFM_PIN_C8]  = 1'b1;
    end
    // serial clock driven out only as master
    if (ck_c9) begin
      drv_d[`PPFM_PIN_C9] = i_serial0_clock_out;
      oe_d[`PPFM_PIN_C9]  = master_q;
    end
    if (tx_c9) begin
      drv_d[`PPFM_PIN_C9] = i_async0_transmit_data;
      oe_d[`PPFM_PIN_C9]  = ~single_q | i_async0_transmit_en;
    end
    if (xo_c9) begin
      drv_d[`PPFM_PIN_C9] = i_crossbar_output8;
      oe_d[`PPFM_PIN_C9]  = 1'b1;
    end
  end

  // pin outputs registered so they start clean from reset
  // the register costs a cycle but keeps decode glitches off the pads
  reg [NPINS-1:0] pin_q;
  reg [NPINS-1:0] oe_q;

  always @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      pin_q <= {NPINS{1'b0}};
      oe_q  <= {NPINS{1'b0}};
    end else begin
      pin_q <= drv_d;
      oe_q  <= oe_d;
    end
  end

  assign o_pin    = pin_q;
  assign o_pin_oe = oe_q;

endmodule

`default_nettype wire

/* verif/ppfm_mux_properties.sv */
// checker for the port pin function multiplexer
`timescale 1ns/10ps
`default_nettype none
module ppfm_mux_properties #(
  parameter NPINS = 9,
  parameter SELW  = 3
) (
  // clock, reset and configuration
  input wire logic                  i_clk_sys,
  input wire logic                  i_arst_n,
  input wire logic                  i_cfg_we,
  input wire logic [NPINS*SELW-1:0] i_cfg_sel,
  input wire logic [NPINS-1:0]      i_cfg_dir,
  input wire logic                  i_conv_b_ref_sel,
  input wire logic                  i_serial0_master,
  input wire logic                  i_async0_single_wire,
  // pins and analog routing
  input wire logic [NPINS-1:0]      o_pin,
  input wire logic [NPINS-1:0]      o_pin_oe,
  input wire logic [7:0]            o_conv_b_channel_en,
  input wire logic                  o_conv_b_ref_high_en,
  input wire logic [3:0]            o_comparator_b_input_en,
  input wire logic [3:0]            o_comparator_ref5_en,
  // serial ports and timer channel
  input wire logic                  i_serial0_clock_out,
  input wire logic                  i_quad_timer_a_channel2_oe,
  input wire logic                  o_serial0_slave_select_n,
  input wire logic                  o_serial0_selected,
  input wire logic                  i_async0_transmit_en
);
  // ----------------------------------------
  // shadow of the loaded configuration
  // ----------------------------------------
  logic [NPINS*SELW-1:0] sel_q;
  logic [NPINS-1:0]      dir_q;
  logic                  ref_q, mst_q, one_q;
  wire  [2:0]            f_b0 = sel_q[2:0];
  wire  [2:0]            f_b2 = sel_q[8:6];
  wire  [2:0]            f_c6 = sel_q[17:15];
  wire  [2:0]            f_c8 = sel_q[23:21];
  wire  [2:0]            f_c9 = sel_q[26:24];
  // whole word taken on the write strobe
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      {sel_q, dir_q, ref_q, mst_q, one_q} <= '0;
    end else if (i_cfg_we) begin
      {sel_q, dir_q, ref_q, mst_q, one_q} <= {i_cfg_sel, i_cfg_dir,
        i_conv_b_ref_sel, i_serial0_master, i_async0_single_wire};
    end
  end
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_arst_n);
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  a_reset_idle: assert property (
    $rose(i_arst_n) |-> o_pin_oe == '0 && o_comparator_ref5_en == 4'h0)
    else $error("pins busy after reset");
  a_gpio_dir: assert property (
    f_b0 == 3'h0 |=> o_pin_oe[0] == $past(dir_q[0]))
    else $error("pin b0 direction wrong");
  a_analog_both: assert property (
    o_conv_b_channel_en[0] == (f_b0 == 3'h1) &&
    o_comparator_b_input_en[3] == (f_b0 == 3'h1))
    else $error("pin b0 analog routing wrong");
  a_ref_choice: assert property (
    f_b2 == 3'h1 |-> o_conv_b_ref_high_en == ref_q &&
    o_conv_b_channel_en[2] == !ref_q)
    else $error("pin b2 reference choice wrong");
  a_comparator_shared_reference: assert property (
    o_comparator_ref5_en == {4{f_c6 == 3'h1}})
    else $error("comparator reference routing wrong");
  a_master_clk: assert property (
    f_c9 == 3'h4 && mst_q |=> o_pin_oe[8] &&
    o_pin[8] == $past(i_serial0_clock_out))
    else $error("master clock not driven");
  a_miso_dir: assert property (
    f_c8 == 3'h4 |=> o_pin_oe[7] == $past(o_serial0_selected))
    else $error("slave data drive wrong");
  a_select_gate: assert property (
    o_serial0_selected == (!mst_q && !o_serial0_slave_select_n))
    else $error("slave selection wrong");
  a_async_tx: assert property (
    f_c9 == 3'h5 |=> o_pin_oe[8] == $past(!one_q || i_async0_transmit_en))
    else $error("transmit pin drive wrong");
  a_timer_drive: assert property (
    f_c6 == 3'h2 |=> o_pin_oe[5] == $past(i_quad_timer_a_channel2_oe))
    else $error("timer pin drive wrong");
  c_slave_sel: cover property (o_serial0_selected);
  c_one_wire: cover property (one_q && f_c9 == 3'h5);
  c_ref_high: cover property (ref_q && f_b2 == 3'h1);
endmodule

bind ppfm_mux ppfm_mux_properties #(.NPINS(NPINS), .SELW(SELW)) u_chk (
  .i_clk_sys(i_clk_sys), .i_arst_n(i_arst_n), .i_cfg_we(i_cfg_we),
  .i_cfg_sel(i_cfg_sel), .i_cfg_dir(i_cfg_dir),
  .i_conv_b_ref_sel(i_conv_b_ref_sel), .i_serial0_master(i_serial0_master),
  .i_async0_single_wire(i_async0_single_wire), .o_pin(o_pin),
  .o_pin_oe(o_pin_oe), .o_conv_b_channel_en(o_conv_b_channel_en),
  .o_conv_b_ref_high_en(o_conv_b_ref_high_en),
  .o_comparator_b_input_en(o_comparator_b_input_en),
  .o_comparator_ref5_en(o_comparator_ref5_en),
  .i_serial0_clock_out(i_serial0_clock_out),
  .i_quad_timer_a_channel2_oe(i_quad_timer_a_channel2_oe),
  .o_serial0_slave_select_n(o_serial0_slave_select_n),
  .o_serial0_selected(o_serial0_selected),
  .i_async0_transmit_en(i_async0_transmit_en));
`default_nettype wire

/* verif/ppfm_board.sv */
// board model that resolves the level on each port pin
`timescale 1ns/10ps
`default_nettype none
module ppfm_board (
  // clock and pin drivers
  input  wire logic       i_clk_sys,
  input  wire logic [8:0] i_pin_dev,
  input  wire logic [8:0] i_pin_oe,
  input  wire logic [8:0] i_ext_val,
  input  wire logic [8:0] i_ext_oe,
  output var  logic [8:0] o_level
);
  logic tgl_q = 1'h0;
  // a floating line changes every cycle instead of keeping its value
  always @(posedge i_clk_sys) tgl_q <= !tgl_q;
  // outside master or peripheral wins where it drives
  always_comb
    for (int k = 0; k < 9; k++)
      o_level[k] = i_ext_oe[k] ? i_ext_val[k] :
                   i_pin_oe[k] ? i_pin_dev[k] : tgl_q ^ k[0];
endmodule
`default_nettype wire

/* verif/test_port_pin_function_mux.sv */
// self-checking bench for the port pin function multiplexer
`timescale 1ns/10ps
`default_nettype none
module test_port_pin_function_mux;
  logic clk, arst_n, we, rsel, mst, one, rh;
  logic sclk_o, sclk_i, miso_o, miso_i, ssn, seld, tx_d, tx_en, rx;
  logic [26:0] sel;
  logic [8:0] dir, out, pin, po, oe, gin, ext_val, ext_oe;
  logic [7:0] ch;
  logic [3:0] cb, cc, r5;
  logic tmr_o, tmr_oe, xo6, xo8, tin, xb3, xb4, xb8, xb9;
  int err_count = 0, cmp_count = 0, cyc = 0;
  ppfm_mux DUT (.i_clk_sys(clk), .i_arst_n(arst_n), .i_cfg_we(we),
    .i_cfg_sel(sel), .i_cfg_dir(dir), .i_cfg_out(out),
    .i_conv_b_ref_sel(rsel), .i_serial0_master(mst),
    .i_async0_single_wire(one), .i_pin(pin), .o_pin(po), .o_pin_oe(oe),
    .o_gpio_in(gin), .o_conv_b_channel_en(ch), .o_conv_b_ref_high_en(rh),
    .o_comparator_b_input_en(cb), .o_comparator_c_input_en(cc),
    .o_comparator_ref5_en(r5), .i_quad_timer_a_channel2_out(tmr_o),
    .i_quad_timer_a_channel2_oe(tmr_oe), .o_quad_timer_a_channel2_in(tin),
    .o_crossbar_input3(xb3), .o_crossbar_input4(xb4),
    .o_crossbar_input8(xb8), .o_crossbar_input9(xb9),
    .i_crossbar_output6(xo6), .i_crossbar_output8(xo8),
    .i_serial0_clock_out(sclk_o),
    .o_serial0_clock_in(sclk_i), .i_serial0_miso_out(miso_o),
    .o_serial0_miso_in(miso_i), .o_serial0_slave_select_n(ssn),
    .o_serial0_selected(seld), .i_async0_transmit_data(tx_d),
    .i_async0_transmit_en(tx_en), .o_async0_receive_data(rx));
  ppfm_board u_board (.i_clk_sys(clk), .i_pin_dev(po), .i_pin_oe(oe),
    .i_ext_val(ext_val), .i_ext_oe(ext_oe), .o_level(pin));
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic chk(input string n, input logic [63:0] s, e);
    cmp_count++;
    if (s !== e) begin
      err_count++;
      $display("Error %s expected %0h seen %0h", n, e, s);
    end
  endtask
  function automatic logic [26:0] fs(int k, logic [2:0] c);
    return 27'(c) << (3 * k);
  endfunction
  // load one configuration word, then let pins and syncs settle
  task automatic cfg(input logic [26:0] s, input logic [8:0] d, o,
                     input logic r, m, w);
    {we, sel, dir, out, rsel, mst, one} = {1'h1, s, d, o, r, m, w};
    @(negedge clk);
    we = 1'h0;
    repeat (3) @(negedge clk);
  endtask
  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_gpio;
    {ext_oe, ext_val} = {9'h0AA, 9'h08A};
    cfg(27'h0, 9'h155, 9'h0F3, 1'h0, 1'h0, 1'h0);
    chk("gpio oe", oe, 9'h155);
    chk("gpio out", po & 9'h155, 9'h051);
    chk("gpio in", gin & 9'h0AA, 9'h08A);
    $display("gpio done");
  endtask
  task automatic t_analog;
    ext_oe = 9'h000;
    cfg(fs(0, 1) | fs(2, 1) | fs(5, 1), 9'h1FF, 9'h0, 1'h0, 1'h0, 1'h0);
    chk("chan", {ch, rh}, 9'h00A);
    chk("cmp", {cb, cc, r5}, 12'h88F);
    chk("analog oe", oe, 9'h1DA);
    cfg(fs(0, 1) | fs(2, 1), 9'h0, 9'h0, 1'h1, 1'h0, 1'h0);
    chk("ref high", {ch, rh, r5}, 13'h030);
    $display("analog done");
  endtask
  task automatic t_master;
    {sclk_o, ext_oe, ext_val} = {1'h1, 9'h080, 9'h080};
    cfg(fs(8, 4) | fs(7, 4), 9'h0, 9'h0, 1'h0, 1'h1, 1'h0);
    chk("master", {oe[8:7], po[8], miso_i}, 4'hB);
    $display("master done");
  endtask
  task automatic t_slave;
    {miso_o, ext_oe, ext_val} = {1'h1, 9'h120, 9'h120};
    cfg(fs(8, 4) | fs(7, 4) | fs(5, 4), 9'h0, 9'h0, 1'h0, 1'h0, 1'h0);
    chk("idle", {seld, oe[8:7], ssn}, 4'h1);
    ext_val = 9'h100; // outside master selects the slave
    repeat (4) @(negedge clk);
    chk("selected", {seld, oe[7], po[7], sclk_i, ssn}, 5'h1E);
    $display("slave done");
  endtask
  task automatic t_async;
    {tx_d, tx_en, ext_oe, ext_val} = {2'h0, 9'h080, 9'h000};
    cfg(fs(8, 5) | fs(7, 5), 9'h0, 9'h0, 1'h0, 1'h0, 1'h0);
    chk("tx", {oe[8], po[8], rx}, 3'h4);
    ext_oe = 9'h100;
    cfg(fs(8, 5), 9'h0, 9'h0, 1'h0, 1'h0, 1'h1);
    chk("one wire rx", {oe[8], rx}, 2'h0);
    {tx_en, ext_oe} = {1'h1, 9'h000};
    repeat (2) @(negedge clk);
    chk("one wire tx", {oe[8], po[8]}, 2'h2);
    $display("async done");
  endtask
  // crossbar inputs and outputs, then the timer channel on c6
  task automatic t_route;
    {tmr_o, tmr_oe, xo6, xo8, ext_oe, ext_val} = {4'hF, 9'h160, 9'h160};
    cfg(fs(5, 3) | fs(6, 3) | fs(7, 6) | fs(8, 3),
        9'h0, 9'h0, 1'h0, 1'h0, 1'h0);
    chk("xbar in", {tin, xb3, xb4, xb8, xb9}, 5'h0E);
    chk("xbar out", {oe, po[7]}, 10'h101);
    {ext_oe, ext_val} = {9'h080, 9'h080};
    cfg(fs(5, 2) | fs(7, 3) | fs(8, 6), 9'h0, 9'h0, 1'h0, 1'h0, 1'h0);
    chk("timer in", {tin, xb3, xb4, xb8, xb9}, 5'h11);
    chk("timer out", {oe, po & 9'h120}, 18'h24120);
    $display("route done");
  endtask
  task automatic t_rereset;
    cfg(fs(5, 1), 9'h1FF, 9'h1FF, 1'h0, 1'h0, 1'h0);
    arst_n = 1'h0;
    @(negedge clk);
    arst_n = 1'h1;
    repeat (2) @(negedge clk);
    chk("rereset", {oe, po, r5}, 22'h0);
    $display("rereset done");
  endtask
  // ----------------------------------------
  // clock, timeout and main sequence
  // ----------------------------------------
  initial begin
    clk = 1'h0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      err_count++;
      stop_test();
    end
  end
  initial begin
    {arst_n, we, sel, dir, out, rsel, mst, one} = '0;
    {sclk_o, miso_o, tx_d, tx_en, ext_val, ext_oe} = '0;
    {tmr_o, tmr_oe, xo6, xo8} = '0;
    repeat (6) @(negedge clk);
    chk("reset", {oe, gin, ch, rh, cb, cc, r5}, 39'h0);
    arst_n = 1'h1;
    @(negedge clk);
    t_gpio();
    t_analog();
    t_master();
    t_slave();
    t_async();
    t_route();
    t_rereset();
    stop_test();
  end
endmodule
`default_nettype wire
